/* core/mbhp_pkg.sv */
/*
  Constants shared by the multi-bus host port: pin slots of the
  synchroniser vector, strap bits, bus modes, cycle states and
  the register map of the Wishbone slave.
  Assumes a 10 MHz system clock.
*/
package mbhp_pkg;
  // Bus flavours, coded as {status_bus_strap, local_bus_strap}
  typedef enum logic [1:0] {
    MBHP_MODE_STROBE = 2'h0,
    MBHP_MODE_STATUS = 2'h1,
    MBHP_MODE_LOCAL = 2'h2,
    MBHP_MODE_ISA = 2'h3
  } mbhp_mode_t;

  typedef enum logic [2:0] {
    MBHP_ST_IDLE = 3'h0,
    MBHP_ST_ADDR = 3'h1,
    MBHP_ST_WAIT = 3'h2,
    MBHP_ST_DONE_LO = 3'h3,
    MBHP_ST_DONE_HI = 3'h4
  } mbhp_state_t;

  // Slots in the synchronised pin vector
  localparam int PIN_RESET = 0;
  localparam int PIN_MAIN_CLOCK_IN = 1;
  localparam int PIN_REFRESH_OR_DISABLE_N = 2;
  localparam int PIN_BHE = 3;
  localparam int PIN_AEN = 4;
  localparam int PIN_START = 5;
  localparam int PIN_IO_READ_N = 6;
  localparam int PIN_IO_WRITE_N = 7;
  localparam int PIN_MEM_READ_N = 8;
  localparam int PIN_MEM_WRITE_N = 9;
  localparam int PIN_CT0 = 10;
  localparam int PIN_CT1 = 11;
  localparam int PIN_FT0 = 12;
  localparam int PIN_FT1 = 13;
  localparam int PIN_STRAP = 14;
  localparam int PIN_CHAIN = 22;
  localparam int STRAP_W = 8;

  // Strap bit positions inside config_straps
  localparam int STRAP_LB = 0;
  localparam int STRAP_MC = 1;
  localparam int STRAP_XCV = 3;
  localparam int STRAP_CD = 4;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 8'hFF;

  // Register map, byte addresses
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACCEPT_CNT = 8'h08;
  localparam logic [7:0] REG_REFUSE_CNT = 8'h0C;

  // Control fields
  localparam int CTL_LOGIC_PWR = 0;
  localparam int CTL_BIAS_PWR = 1;
  localparam int CTL_VSYNC_IRQ = 2;
  localparam int CTL_IRQ_LOW = 3;
  localparam int CTL_W = 4;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 4'h0;

  // Status fields
  localparam int STS_MODE = 0;
  localparam int STS_XCV = 2;
  localparam int STS_CDBL = 3;
  localparam int STS_ICT = 4;
  localparam int STS_FLOAT = 5;
  localparam int STS_BUSY = 6;
  localparam int STS_STRAPS = 8;
endpackage

/* core/mbhp_host_port.sv */
/*
  Host bus front end of a flat-panel display controller: cycle decode
  for four bus flavours, ready generation, reset-time straps, the
  continuity test chain and the all-pins float test.
  Assumes every pin input is asynchronous to sys_clk_i, that the
  display core answers each acc_req_o with acc_done_i, and that a
  pad ring resolves the three-signal two-way pins.
*/
// Summary of operation
// - Refresh/disable low refuses display memory accesses
// - Byte-high-enable low adds upper byte
// - ISA: latched address enable 0 validates I/O
// - Other modes: select 1 memory, 0 I/O
// - Start strobe input; ISA drives activity indicator
// - I/O read: ISA read, local clock, else command phase
// - Status mode: setup low disables all functions; here it only idles bus cycles, registers and test modes still run
// - Local mode: drive I/O-write low claiming cycle
// - Strobe/local modes: memory-read low means read
// - Status pair: 01 read, 10 write
// - Strobe ignores memory-write; local drives bus-size low
// - ISA/status: ready low inserts wait states
// - Strobe/local ready low completes; high, then float
// - Two straps select bus type
// - Transceiver strap 0 turns logic power into direction
// - Clock-double strap low enables clock doubling
// - Enter chain test on clock rise, straps low
// - Chain test: AND of pins on frame marker
// - Leave chain test when conditions fail
// - Float straps low at clock rise floats pins
// - Bias output: vsync interrupt or data-select
// - Straps captured at reset falling edge
`timescale 1ns/1ps
`default_nettype none
module mbhp_host_port #(
  parameter int CHAIN_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_pin_i,
  input wire logic main_clock_in_i,
  input wire logic refresh_or_disable_n_i,
  input wire logic byte_high_en_n_i,
  input wire logic address_enable_gate_i,
  input wire logic cycle_start_n_i,
  output logic cycle_start_n_o,
  output logic cycle_start_n_oe_o,
  input wire logic io_read_n_i,
  input wire logic io_write_n_i,
  output logic io_write_n_o,
  output logic io_write_n_oe_o,
  input wire logic mem_read_n_i,
  input wire logic mem_write_n_i,
  output logic mem_write_n_o,
  output logic mem_write_n_oe_o,
  output logic cycle_done_n_o,
  output logic cycle_done_n_oe_o,
  input wire logic [7:0] config_straps_i,
  input wire logic chain_test_en0_n_i,
  input wire logic chain_test_en1_n_i,
  input wire logic float_test_en0_n_i,
  input wire logic float_test_en1_n_i,
  input wire logic [CHAIN_W-1:0] chain_pins_i,
  input wire logic frame_marker_core_i,
  output logic frame_marker_o,
  output logic frame_marker_oe_o,
  input wire logic vsync_i,
  output logic panel_logic_power_en_o,
  output logic panel_bias_power_en_o,
  output logic pins_float_o,
  output logic clock_double_en_o,
  output logic acc_req_o,
  output logic acc_mem_o,
  output logic acc_write_o,
  output logic acc_hi_byte_o,
  input wire logic acc_done_i
);
  localparam int NP = mbhp_pkg::PIN_CHAIN + CHAIN_W;

  logic [NP-1:0] pin_raw;
  logic [NP-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg, pin_d_reg;
  logic [NP-1:0] pin_next, pin_fall, pin_rise;

  assign pin_raw = {chain_pins_i, config_straps_i, float_test_en1_n_i, float_test_en0_n_i,
    chain_test_en1_n_i, chain_test_en0_n_i, mem_write_n_i, mem_read_n_i, io_write_n_i,
    io_read_n_i, cycle_start_n_i, address_enable_gate_i, byte_high_en_n_i,
    refresh_or_disable_n_i, main_clock_in_i, reset_pin_i};

  // A bit moves only once the second and third stages agree
  assign pin_next = (~(sync2_reg ^ sync3_reg) & sync2_reg) | ((sync2_reg ^ sync3_reg) & pin_reg);
  assign pin_fall = pin_d_reg & ~pin_reg;
  assign pin_rise = ~pin_d_reg & pin_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      pin_reg <= '1;
      pin_d_reg <= '1;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= pin_next;
      pin_d_reg <= pin_reg;
    end
  end

  // Straps and mode
  logic [mbhp_pkg::STRAP_W-1:0] strap_reg;
  mbhp_pkg::mbhp_mode_t mode;
  logic is_isa, is_status, is_strobe, is_local, xcv_mode;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_reg <= mbhp_pkg::STRAP_RESET;
    end else if (pin_fall[mbhp_pkg::PIN_RESET]) begin
      strap_reg <= pin_reg[mbhp_pkg::PIN_STRAP +: mbhp_pkg::STRAP_W];
    end
  end

  assign mode = mbhp_pkg::mbhp_mode_t'({strap_reg[mbhp_pkg::STRAP_MC],
    strap_reg[mbhp_pkg::STRAP_LB]});
  assign is_isa = (mode == mbhp_pkg::MBHP_MODE_ISA);
  assign is_status = (mode == mbhp_pkg::MBHP_MODE_STATUS);
  assign is_strobe = (mode == mbhp_pkg::MBHP_MODE_STROBE);
  assign is_local = (mode == mbhp_pkg::MBHP_MODE_LOCAL);
  assign xcv_mode = ~strap_reg[mbhp_pkg::STRAP_XCV];
  assign clock_double_en_o = ~strap_reg[mbhp_pkg::STRAP_CD];

  // Test modes, evaluated on each main clock rise
  logic ict_reg, float_reg, test_ok_ict, test_ok_float;
  assign test_ok_ict = ~pin_reg[mbhp_pkg::PIN_CT0] & ~pin_reg[mbhp_pkg::PIN_CT1] &
    pin_reg[mbhp_pkg::PIN_RESET];
  assign test_ok_float = ~pin_reg[mbhp_pkg::PIN_FT0] & ~pin_reg[mbhp_pkg::PIN_FT1] &
    pin_reg[mbhp_pkg::PIN_RESET];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ict_reg <= 1'b0;
      float_reg <= 1'b0;
    end else if (pin_rise[mbhp_pkg::PIN_MAIN_CLOCK_IN]) begin
      ict_reg <= test_ok_ict;
      float_reg <= test_ok_float;
    end
  end

  logic quiet;
  assign quiet = ict_reg | float_reg;
  assign pins_float_o = quiet;

  // Bus cycle decode
  mbhp_pkg::mbhp_state_t state_reg;
  logic aen_lat_reg, sel_mem_reg, dir_rd_reg, hi_reg, stat_hi_reg, stat_lo_reg;
  logic lclk_rise, step, setup_off, start_fall, cmd_fall;
  logic isa_fall, isa_mem, isa_wr, isa_ok;
  logic lb_start, st_issue, st_refuse;
  logic iss_mem, iss_wr, iss_hi, cmd_ok;

  assign lclk_rise = pin_rise[mbhp_pkg::PIN_IO_READ_N];
  assign step = is_local ? lclk_rise : 1'b1;
  assign setup_off = is_status & ~pin_reg[mbhp_pkg::PIN_IO_WRITE_N];
  assign start_fall = pin_fall[mbhp_pkg::PIN_START];
  assign cmd_fall = pin_fall[mbhp_pkg::PIN_IO_READ_N];

  assign isa_fall = |pin_fall[mbhp_pkg::PIN_MEM_WRITE_N:mbhp_pkg::PIN_IO_READ_N];
  assign isa_mem = pin_fall[mbhp_pkg::PIN_MEM_READ_N] | pin_fall[mbhp_pkg::PIN_MEM_WRITE_N];
  assign isa_wr = pin_fall[mbhp_pkg::PIN_IO_WRITE_N] | pin_fall[mbhp_pkg::PIN_MEM_WRITE_N];
  assign isa_ok = isa_mem ? pin_reg[mbhp_pkg::PIN_REFRESH_OR_DISABLE_N] : ~aen_lat_reg;
  assign lb_start = lclk_rise & ~pin_reg[mbhp_pkg::PIN_START];

  // Command phase for status and strobe flavours
  always_comb begin
    cmd_ok = 1'b0;
    iss_wr = ~dir_rd_reg;
    if (is_status) begin
      cmd_ok = stat_hi_reg ^ stat_lo_reg;
      iss_wr = stat_hi_reg;
    end else begin
      cmd_ok = 1'b1;
    end
    if (sel_mem_reg & ~pin_reg[mbhp_pkg::PIN_REFRESH_OR_DISABLE_N]) begin
      cmd_ok = 1'b0;
    end
  end

  always_comb begin
    st_issue = 1'b0;
    st_refuse = 1'b0;
    iss_mem = sel_mem_reg;
    iss_hi = hi_reg;
    if (quiet | setup_off) begin
      st_issue = 1'b0;
    end else if (state_reg == mbhp_pkg::MBHP_ST_IDLE && is_isa && isa_fall) begin
      st_issue = isa_ok;
      st_refuse = ~isa_ok;
      iss_mem = isa_mem;
      iss_hi = ~pin_reg[mbhp_pkg::PIN_BHE];
    end else if (state_reg == mbhp_pkg::MBHP_ST_IDLE && is_local && lb_start) begin
      st_issue = pin_reg[mbhp_pkg::PIN_AEN] ? pin_reg[mbhp_pkg::PIN_REFRESH_OR_DISABLE_N] : 1'b1;
      st_refuse = ~st_issue;
      iss_mem = pin_reg[mbhp_pkg::PIN_AEN];
      iss_hi = ~pin_reg[mbhp_pkg::PIN_BHE];
    end else if (state_reg == mbhp_pkg::MBHP_ST_ADDR && cmd_fall) begin
      st_issue = cmd_ok;
      st_refuse = ~cmd_ok;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aen_lat_reg <= 1'b1;
    end else if (state_reg == mbhp_pkg::MBHP_ST_IDLE && ~isa_fall) begin
      // Transparent between cycles, frozen once a strobe falls
      aen_lat_reg <= pin_reg[mbhp_pkg::PIN_AEN];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sel_mem_reg <= 1'b0;
      dir_rd_reg <= 1'b1;
      hi_reg <= 1'b0;
      stat_hi_reg <= 1'b1;
      stat_lo_reg <= 1'b1;
    end else if (state_reg == mbhp_pkg::MBHP_ST_IDLE && start_fall) begin
      sel_mem_reg <= pin_reg[mbhp_pkg::PIN_AEN];
      dir_rd_reg <= ~pin_reg[mbhp_pkg::PIN_MEM_READ_N];
      hi_reg <= ~pin_reg[mbhp_pkg::PIN_BHE];
      stat_hi_reg <= pin_reg[mbhp_pkg::PIN_MEM_READ_N];
      stat_lo_reg <= pin_reg[mbhp_pkg::PIN_MEM_WRITE_N];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || quiet || setup_off) begin
      state_reg <= mbhp_pkg::MBHP_ST_IDLE;
    end else begin
      unique case (state_reg)
        mbhp_pkg::MBHP_ST_IDLE: begin
          if (st_issue) begin
            state_reg <= mbhp_pkg::MBHP_ST_WAIT;
          end else if ((is_status || is_strobe) && start_fall) begin
            state_reg <= mbhp_pkg::MBHP_ST_ADDR;
          end
        end
        mbhp_pkg::MBHP_ST_ADDR: begin
          if (st_issue) begin
            state_reg <= mbhp_pkg::MBHP_ST_WAIT;
          end else if (st_refuse) begin
            state_reg <= mbhp_pkg::MBHP_ST_IDLE;
          end
        end
        mbhp_pkg::MBHP_ST_WAIT: begin
          if (acc_done_i) begin
            // Wait-state flavours just release ready; the others pulse it low
            state_reg <= (is_isa || is_status) ? mbhp_pkg::MBHP_ST_DONE_HI :
              mbhp_pkg::MBHP_ST_DONE_LO;
          end
        end
        mbhp_pkg::MBHP_ST_DONE_LO: begin
          if (step) begin
            state_reg <= mbhp_pkg::MBHP_ST_DONE_HI;
          end
        end
        mbhp_pkg::MBHP_ST_DONE_HI: begin
          if (step) begin
            state_reg <= mbhp_pkg::MBHP_ST_IDLE;
          end
        end
        default: begin
          state_reg <= mbhp_pkg::MBHP_ST_IDLE;
        end
      endcase
    end
  end

  // Request to the display core
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      acc_req_o <= 1'b0;
      acc_mem_o <= 1'b0;
      acc_write_o <= 1'b0;
      acc_hi_byte_o <= 1'b0;
    end else begin
      acc_req_o <= st_issue;
      if (st_issue) begin
        acc_mem_o <= iss_mem;
        acc_write_o <= is_isa ? isa_wr : (is_local ? pin_reg[mbhp_pkg::PIN_MEM_READ_N] : iss_wr);
        acc_hi_byte_o <= iss_hi;
      end
    end
  end

  // Pin drivers
  logic busy, in_wait;
  assign busy = (state_reg != mbhp_pkg::MBHP_ST_IDLE) && (state_reg != mbhp_pkg::MBHP_ST_ADDR);
  assign in_wait = (state_reg == mbhp_pkg::MBHP_ST_WAIT);

  always_comb begin
    cycle_done_n_o = 1'b1;
    cycle_done_n_oe_o = busy & ~quiet;
    if (in_wait && (is_isa || is_status)) begin
      cycle_done_n_o = 1'b0;
    end else if (state_reg == mbhp_pkg::MBHP_ST_DONE_LO) begin
      cycle_done_n_o = 1'b0;
    end
  end

  assign cycle_start_n_o = busy;
  assign cycle_start_n_oe_o = is_isa & ~quiet;
  assign io_write_n_o = ~busy;
  assign io_write_n_oe_o = is_local & ~quiet;
  assign mem_write_n_o = 1'b0;
  assign mem_write_n_oe_o = is_local & busy & ~quiet;

  // Chain result replaces the frame marker in continuity test
  assign frame_marker_o = ict_reg ? &pin_reg[mbhp_pkg::PIN_CHAIN +: CHAIN_W] :
    frame_marker_core_i;
  assign frame_marker_oe_o = ict_reg | ~float_reg;

  // Register file
  logic [mbhp_pkg::CTL_W-1:0] control_reg;
  logic [CNT_W-1:0] accept_cnt_reg, refuse_cnt_reg;
  logic wb_hit, rd_dir;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      control_reg <= mbhp_pkg::CONTROL_RESET;
    end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == mbhp_pkg::REG_CONTROL) begin
      control_reg <= wb_dat_i[mbhp_pkg::CTL_W-1:0];
    end
  end

  // Counters saturate rather than wrap so a long soak stays readable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      accept_cnt_reg <= '0;
      refuse_cnt_reg <= '0;
    end else begin
      if (st_issue && ~&accept_cnt_reg) begin
        accept_cnt_reg <= accept_cnt_reg + 1'b1;
      end
      if (st_refuse && ~&refuse_cnt_reg) begin
        refuse_cnt_reg <= refuse_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_hit && !wb_we_i) begin
      wb_dat_o <= 32'h00000000;
      unique case (wb_adr_i)
        mbhp_pkg::REG_CONTROL: wb_dat_o[mbhp_pkg::CTL_W-1:0] <= control_reg;
        mbhp_pkg::REG_STATUS: begin
          wb_dat_o[mbhp_pkg::STS_MODE +: 2] <= mode;
          wb_dat_o[mbhp_pkg::STS_XCV] <= xcv_mode;
          wb_dat_o[mbhp_pkg::STS_CDBL] <= clock_double_en_o;
          wb_dat_o[mbhp_pkg::STS_ICT] <= ict_reg;
          wb_dat_o[mbhp_pkg::STS_FLOAT] <= float_reg;
          wb_dat_o[mbhp_pkg::STS_BUSY] <= busy;
          wb_dat_o[mbhp_pkg::STS_STRAPS +: mbhp_pkg::STRAP_W] <= strap_reg;
        end
        mbhp_pkg::REG_ACCEPT_CNT: wb_dat_o[CNT_W-1:0] <= accept_cnt_reg;
        mbhp_pkg::REG_REFUSE_CNT: wb_dat_o[CNT_W-1:0] <= refuse_cnt_reg;
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Panel outputs; the float test parks them low since they have no enable
  assign rd_dir = busy & ~acc_write_o;
  always_comb begin
    panel_logic_power_en_o = control_reg[mbhp_pkg::CTL_LOGIC_PWR];
    panel_bias_power_en_o = control_reg[mbhp_pkg::CTL_BIAS_PWR];
    if (xcv_mode) begin
      panel_logic_power_en_o = rd_dir;
    end
    if (is_status) begin
      panel_bias_power_en_o = ~(busy & acc_mem_o);
    end else if (control_reg[mbhp_pkg::CTL_VSYNC_IRQ]) begin
      panel_bias_power_en_o = vsync_i ^ control_reg[mbhp_pkg::CTL_IRQ_LOW];
    end
    if (quiet) begin
      panel_logic_power_en_o = 1'b0;
      panel_bias_power_en_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* testbench/mbhp_checker.sv */
/*
  Concurrent checks on the host port pins and the Wishbone slave.
  Assumes binding to every mbhp_host_port, one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mbhp_chk #(
  parameter int CHAIN_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic refresh_or_disable_n_i,
  input wire logic cycle_start_n_o,
  input wire logic cycle_start_n_oe_o,
  input wire logic io_write_n_o,
  input wire logic io_write_n_oe_o,
  input wire logic mem_write_n_o,
  input wire logic mem_write_n_oe_o,
  input wire logic cycle_done_n_o,
  input wire logic cycle_done_n_oe_o,
  input wire logic [CHAIN_W-1:0] chain_pins_i,
  input wire logic frame_marker_o,
  input wire logic frame_marker_oe_o,
  input wire logic pins_float_o,
  input wire logic acc_req_o,
  input wire logic acc_mem_o,
  input wire logic acc_done_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ready_end;
    cycle_done_n_oe_o && cycle_done_n_o ##1 !cycle_done_n_oe_o;
  endsequence
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_req_pulse: assert property (acc_req_o |=> !acc_req_o)
    else $error("request held");
  // Sync delay is under eight cycles, so a stable low level must have won
  a_refresh_refuse: assert property (
    !refresh_or_disable_n_i [*8] |-> !(acc_req_o && acc_mem_o)) else $error("memory taken");
  a_isa_wait: assert property (
    acc_req_o && cycle_start_n_oe_o |-> cycle_done_n_oe_o && !cycle_done_n_o)
    else $error("no wait state");
  a_isa_release: assert property (
    acc_done_i && cycle_start_n_oe_o && cycle_done_n_oe_o |-> ##[0:2] s_ready_end)
    else $error("ready not released");
  a_ready_float: assert property ($fell(cycle_done_n_oe_o) |-> $past(cycle_done_n_o))
    else $error("ready floated low");
  a_isa_activity: assert property (
    acc_req_o && cycle_start_n_oe_o |=> cycle_start_n_o) else $error("activity low");
  a_bus_size: assert property (mem_write_n_oe_o |-> !mem_write_n_o)
    else $error("bus size high");
  a_local_claim: assert property (
    acc_req_o && io_write_n_oe_o |-> ##[0:1] !io_write_n_o) else $error("no claim");
  a_chain_and: assert property (
    $stable(chain_pins_i) [*8] ##0 (pins_float_o && frame_marker_oe_o)
    |-> frame_marker_o == &chain_pins_i) else $error("chain marker wrong");
endmodule
bind mbhp_host_port mbhp_chk #(.CHAIN_W(CHAIN_W)) chk_u (
  .sys_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .refresh_or_disable_n_i,
  .cycle_start_n_o, .cycle_start_n_oe_o, .io_write_n_o, .io_write_n_oe_o,
  .mem_write_n_o, .mem_write_n_oe_o, .cycle_done_n_o, .cycle_done_n_oe_o,
  .chain_pins_i, .frame_marker_o, .frame_marker_oe_o, .pins_float_o,
  .acc_req_o, .acc_mem_o, .acc_done_i
);
`default_nettype wire

/* testbench/mbhp_host_model.sv */
/*
  Host side partner: drives strobes, straps and test pins, and answers
  each access request as the display core after lat cycles.
  Assumes its tasks are called from one bench process.
*/
`timescale 1ns/1ps
`default_nettype none
module mbhp_host_model (
  input wire logic clk_i,
  input wire logic acc_req_i,
  output logic acc_done_o,
  output logic reset_pin_o,
  output logic main_clk_o,
  output logic refresh_n_o,
  output logic bhe_n_o,
  output logic aen_o,
  output logic start_n_o,
  output logic [3:0] strb_n_o,
  output logic [7:0] straps_o,
  output logic [3:0] test_n_o,
  output logic [7:0] chain_o
);
  int lat = 3;
  int n = 0;
  initial begin
    {reset_pin_o, main_clk_o, refresh_n_o, bhe_n_o, aen_o, start_n_o} = 6'h2D;
    {strb_n_o, test_n_o, straps_o, chain_o} = 24'hFFFFFF;
    acc_done_o = 1'h0;
  end
  always @(posedge clk_i) begin
    acc_done_o <= 1'h0;
    if (acc_req_i) n <= lat;
    else if (n > 0) begin
      n <= n - 1;
      if (n == 1) acc_done_o <= 1'h1;
    end
  end
  task automatic w(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // Straps held well past the synced reset fall
  task automatic strap(input logic [7:0] s);
    straps_o <= s;
    reset_pin_o <= 1'h1;
    w(8);
    reset_pin_o <= 1'h0;
    w(8);
  endtask
  // strb order: mem write, mem read, io write, io read
  task automatic frame(input logic [3:0] pre, cmd, input logic a, st);
    aen_o <= a;
    strb_n_o <= pre;
    start_n_o <= ~st;
    w(8);
    strb_n_o <= cmd;
    w(20);
    strb_n_o <= 4'hF;
    start_n_o <= 1'h1;
    w(8);
  endtask
  // Double-rate clock on io read, 800 ns period, only inside the frame
  task automatic local_cycle(input logic rd);
    aen_o <= 1'h1;
    strb_n_o[2] <= ~rd;
    start_n_o <= 1'h0;
    for (int i = 0; i < 12; i++) begin
      w(4);
      strb_n_o[0] <= ~strb_n_o[0];
      if (i == 2) start_n_o <= 1'h1;
    end
    w(8);
    strb_n_o <= 4'hF;
  endtask
  // test_n: chain en0, chain en1, float en0, float en1
  task automatic test(input logic [3:0] en, input logic r);
    reset_pin_o <= r;
    test_n_o <= en;
    w(8);
    main_clk_o <= 1'h1;
    w(8);
    main_clk_o <= 1'h0;
    w(2);
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
/*
  Bench for mbhp_host_port: registers, all four bus flavours, straps
  and pin test modes. Assumes mbhp_host_model as host and core.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic frame_marker_core_i;
  logic vsync_i;
  logic [31:0] rdat, wb_dat_o;
  logic wb_ack_o, cycle_start_n_o, cycle_start_n_oe_o, io_write_n_o, io_write_n_oe_o;
  logic mem_write_n_o, mem_write_n_oe_o, cycle_done_n_o, cycle_done_n_oe_o, frame_marker_o;
  logic frame_marker_oe_o, panel_logic_power_en_o, panel_bias_power_en_o, pins_float_o;
  logic clock_double_en_o, acc_req_o, acc_mem_o, acc_write_o, acc_hi_byte_o, acc_done_i;
  logic reset_pin_i, main_clock_in_i, refresh_or_disable_n_i, byte_high_en_n_i, start_h;
  logic address_enable_gate_i, cycle_start_n_i, io_read_n_i, io_write_n_i, mem_read_n_i;
  logic mem_write_n_i, chain_test_en0_n_i, chain_test_en1_n_i, float_test_en0_n_i;
  logic float_test_en1_n_i;
  logic [7:0] config_straps_i, chain_pins_i;
  logic [3:0] strb, test_n;
  logic [3:0] bias_ctl [3] = '{4'h2, 4'h4, 4'hC};
  logic bias_exp [3] = '{1'h1, 1'h0, 1'h1};
  int miscompares = 0;
  int check_count = 0;
  int acc_e = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  mbhp_host_port dut_u (.*);
  mbhp_host_model host_u (
    .clk_i(sys_clk_i),
    .acc_req_i(acc_req_o),
    .acc_done_o(acc_done_i),
    .reset_pin_o(reset_pin_i),
    .main_clk_o(main_clock_in_i),
    .refresh_n_o(refresh_or_disable_n_i),
    .bhe_n_o(byte_high_en_n_i),
    .aen_o(address_enable_gate_i),
    .start_n_o(start_h),
    .strb_n_o(strb),
    .straps_o(config_straps_i),
    .test_n_o(test_n),
    .chain_o(chain_pins_i)
  );
  assign cycle_start_n_i = cycle_start_n_oe_o ? cycle_start_n_o : start_h;
  assign io_read_n_i = strb[0];
  assign io_write_n_i = io_write_n_oe_o ? io_write_n_o : strb[1];
  assign mem_read_n_i = strb[2];
  assign mem_write_n_i = mem_write_n_oe_o ? mem_write_n_o : strb[3];
  assign {chain_test_en0_n_i, chain_test_en1_n_i, float_test_en0_n_i, float_test_en1_n_i} = test_n;
  task automatic chk(input string n, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge sys_clk_i);
    end while (wb_ack_o !== 1'h1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'h0, a, 32'h0, 4'hF);
  endtask
  task automatic bus(input logic [3:0] pre, cmd, input logic a, st, ok, m, wr, h);
    host_u.frame(pre, cmd, a, st);
    if (ok) acc_e++;
    rd(mbhp_pkg::REG_ACCEPT_CNT);
    chk("accepted", rdat, 32'(acc_e));
    if (ok) chk("kind", {acc_mem_o, acc_write_o, acc_hi_byte_o}, {m, wr, h});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    summarize();
  end
  initial begin
    frame_marker_core_i <= 1'h0;
    vsync_i <= 1'h0;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    rd(mbhp_pkg::REG_CONTROL);
    chk("control reset", rdat, 32'h0);
    host_u.strap(8'hE7);
    wb(1'h1, mbhp_pkg::REG_CONTROL, 32'h1, 4'hF);
    chk("clock double", clock_double_en_o, 1'h1);
    chk("logic power", panel_logic_power_en_o, 1'h0);
    host_u.strap(8'hFF);
    chk("clock double", clock_double_en_o, 1'h0);
    chk("logic power", panel_logic_power_en_o, 1'h1);
    rd(mbhp_pkg::REG_STATUS);
    chk("status", rdat & 32'hFF03, 32'hFF03);
    wb(1'h1, mbhp_pkg::REG_CONTROL, 32'hF, 4'h0);
    rd(mbhp_pkg::REG_CONTROL);
    chk("control", rdat, 32'h1);
    rd(8'h10);
    chk("unmapped", rdat, 32'h0);
    foreach (bias_ctl[i]) begin
      wb(1'h1, mbhp_pkg::REG_CONTROL, {28'h0, bias_ctl[i]}, 4'h1);
      chk("bias", panel_bias_power_en_o, bias_exp[i]);
    end
    // Active-low interrupt polarity: a high vsync drives the pin low
    vsync_i <= 1'h1;
    @(posedge sys_clk_i);
    chk("bias", panel_bias_power_en_o, 1'h0);
    $display("test registers done");
    host_u.lat = 1;
    bus(4'hF, 4'hE, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    host_u.lat = 4;
    bus(4'hF, 4'hD, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    host_u.bhe_n_o <= 1'h0;
    bus(4'hF, 4'h7, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
    host_u.bhe_n_o <= 1'h1;
    host_u.refresh_n_o <= 1'h0;
    bus(4'hF, 4'hB, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    host_u.refresh_n_o <= 1'h1;
    rd(mbhp_pkg::REG_REFUSE_CNT);
    chk("refused", rdat, 32'h2);
    $display("test isa done");
    host_u.strap(8'hFD);
    rd(mbhp_pkg::REG_STATUS);
    chk("mode", rdat[1:0], 2'h1);
    bus(4'h7, 4'h6, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    bus(4'hB, 4'hA, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    bus(4'h3, 4'h2, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    bus(4'hF, 4'hE, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    bus(4'h5, 4'h4, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    $display("test status bus done");
    host_u.strap(8'hFC);
    bus(4'hB, 4'hA, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    bus(4'h7, 4'h6, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
    $display("test strobe bus done");
    host_u.strap(8'hFE);
    host_u.local_cycle(1'h1);
    rd(mbhp_pkg::REG_ACCEPT_CNT);
    chk("accepted", rdat, 32'(acc_e + 1));
    chk("kind", {acc_mem_o, acc_write_o}, 2'h2);
    $display("test local bus done");
    host_u.test(4'h3, 1'h1);
    chk("float", pins_float_o, 1'h1);
    chk("marker", frame_marker_o, 1'h1);
    host_u.chain_o <= 8'hF7;
    host_u.w(10);
    chk("marker", frame_marker_o, 1'h0);
    host_u.chain_o <= 8'hFF;
    host_u.test(4'h3, 1'h0);
    chk("float", pins_float_o, 1'h0);
    host_u.test(4'hC, 1'h1);
    chk("float", pins_float_o, 1'h1);
    host_u.test(4'hF, 1'h1);
    chk("float", pins_float_o, 1'h0);
    // Outside the chain test the marker follows the display core
    frame_marker_core_i <= 1'h1;
    host_u.w(1);
    chk("marker", frame_marker_o, 1'h1);
    $display("test pin modes done");
    summarize();
  end
endmodule
`default_nettype wire
